/* File: rtl/exec_unit.v */
// Summary of operation
// - Quick compare: operand against sign-extended 4-bit constant, sets flags.
// - Block compare over disp bytes; only 1 to 16 bytes accepted.
// - Boolean invert flips bit zero only.
// - Save condition writes one or zero at operand length.
// - Shifts and rotate go left or right by count sign.
// - Field extract reads unaligned field from memory, right-aligned result.
// - Field insert writes aligned source into field, other bits kept.
// - Short forms take field offset and length from immediates.
// - Index step: accum times (length plus one) plus subscript.
// - Strings use R0 count, R1/R2 pointers, R3 table, R4 match value.
// - Backward option decrements string pointers after each step.
// - Until option stops when string-one element equals R4.
// - While option stops when string-one element differs from R4.
// - Each step decrements R0; string ends when R0 is zero.
// - Translating move stores table entry selected by source byte.
// - Translating compare translates string-one byte before comparing.
// - Translating skip translates byte before until/while test.
// - Add-compare-branch adds constant, stores sum, branches if non-zero.
// - Trap return is supervisor only, pops PC and status.
// - Interrupt return is supervisor only, ends service, restores state.
// - Enter pushes listed registers and allocates frame, sets frame pointer.
// - Exit releases frame then pops listed registers in reverse.
// - Length suffix selects byte, word or double word operands.
`include "exec_defines.vh"
`default_nettype none
module exec_unit (
  // Clock and reset
  input wire CLK,
  input wire RST_N,
  // Command
  input wire START,
  input wire [4:0] OP,
  input wire [1:0] SIZE,
  input wire OPT_BACK,
  input wire OPT_UNTIL,
  input wire OPT_WHILE,
  input wire OPT_XLAT,
  input wire SUPERVISOR,
  // Operands
  input wire [31:0] SRC,
  input wire [31:0] DST,
  input wire [31:0] AUX,
  input wire [31:0] DISP,
  input wire [3:0] SHORT_VAL,
  input wire [3:0] COND,
  input wire [7:0] IMM_OFF,
  input wire [7:0] IMM_LEN,
  input wire [7:0] REG_LIST,
  // Core state in
  input wire [255:0] REGS_IN,
  input wire [31:0] SP_IN,
  input wire [31:0] FP_IN,
  input wire [4:0] FLAGS_IN,
  // Memory bus
  output wire MEM_REQ,
  output wire MEM_WE,
  output wire [1:0] MEM_SIZE,
  output wire [31:0] MEM_ADDR,
  output wire [31:0] MEM_WDATA,
  input wire [31:0] MEM_RDATA,
  input wire MEM_ACK,
  // Results
  output wire BUSY,
  output wire DONE,
  output wire [31:0] RESULT,
  output wire RESULT_VALID,
  output wire [4:0] FLAGS_OUT,
  output wire BRANCH,
  output wire TRAP_ILLEGAL,
  output wire [255:0] REGS_OUT,
  output wire REGS_VALID,
  output wire [31:0] SP_OUT,
  output wire [31:0] FP_OUT,
  output wire [31:0] PC_OUT,
  output wire [15:0] PSR_OUT,
  output wire PC_VALID,
  output wire INT_END
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [1:0] state_r;
  reg [2:0] phase_r;
  reg [2:0] ret_r;
  reg [4:0] op_r;
  reg [1:0] size_r;
  reg back_r, until_r, while_r, xlat_r;
  reg [31:0] src_r, a_r, b_r, cnt_r, disp_r, tmp_r, mdata_r;
  reg [7:0] list_r;
  reg [3:0] idx_r;
  reg [2:0] bitpos_r;
  reg [5:0] len_r;
  reg [31:0] gpr [0:`REG_CNT-1];
  reg mem_req_r, mem_we_r;
  reg [1:0] mem_size_r;
  reg [31:0] mem_addr_r, mem_wdata_r;
  reg busy_r, done_r, result_valid_r, branch_r, trap_r, regs_valid_r, pc_valid_r, int_end_r;
  reg [31:0] result_r, sp_r, fp_r, pc_r;
  reg [15:0] psr_r;
  reg [4:0] flags_r;
  integer i;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [31:0] szmask;
    input [1:0] s;
    begin
      szmask = (s == `SZ_B) ? 32'h000000FF : (s == `SZ_W) ? 32'h0000FFFF : 32'hFFFFFFFF;
    end
  endfunction
  function [31:0] esz;
    input [1:0] s;
    begin
      esz = (s == `SZ_B) ? 32'h00000001 : (s == `SZ_W) ? 32'h00000002 : 32'h00000004;
    end
  endfunction
  // Unsigned/signed comparison flags of two same-length elements
  function [4:0] cmp_flags;
    input [31:0] x;
    input [31:0] y;
    input [4:0] f;
    begin
      cmp_flags = f;
      cmp_flags[`FLG_Z] = (x == y);
      cmp_flags[`FLG_L] = (x > y);
      cmp_flags[`FLG_N] = ($signed(x) > $signed(y));
    end
  endfunction
  task mem_go;
    input we;
    input [1:0] sz;
    input [31:0] ad;
    input [31:0] wd;
    input [2:0] ret;
    begin
      mem_req_r <= 1'b1;
      mem_we_r <= we;
      mem_size_r <= sz;
      mem_addr_r <= ad;
      mem_wdata_r <= wd;
      ret_r <= ret;
      state_r <= `ST_MEM;
    end
  endtask
  task finish;
    begin
      state_r <= `ST_IDLE;
      busy_r <= 1'b0;
      done_r <= 1'b1;
    end
  endtask
  // ----------------------------------------
  // Datapath
  // ----------------------------------------
  wire short_form = (OP == `OP_SEXT) || (OP == `OP_SINS);
  wire [31:0] foff = short_form ? {24'h000000, IMM_OFF} : AUX;
  wire [5:0] flen = short_form ? IMM_LEN[5:0] : DISP[5:0];
  wire [31:0] faddr = DST + {{3{foff[31]}}, foff[31:3]};
  wire [31:0] step = back_r ? (32'h00000000 - esz(size_r)) : esz(size_r);
  wire [31:0] elem = xlat_r ? {24'h000000, mdata_r[7:0]} : tmp_r;
  wire [31:0] match = gpr[`R_MATCH] & szmask(size_r);
  wire [31:0] alu_res;
  wire [4:0] alu_flags;
  int_alu u_alu (
    .op(busy_r ? op_r : OP),
    .size(busy_r ? `SZ_D : SIZE),
    .short_val(SHORT_VAL),
    .cond(COND),
    .flags_in(FLAGS_IN),
    .a(busy_r ? mdata_r : SRC),
    .b(busy_r ? src_r : DST),
    .c(AUX),
    .fpos(bitpos_r),
    .flen(len_r),
    .res(alu_res),
    .flags_res(alu_flags)
  );
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= `ST_IDLE;
      phase_r <= 3'h0;
      ret_r <= 3'h0;
      op_r <= 5'h00;
      size_r <= `SZ_B;
      {back_r, until_r, while_r, xlat_r} <= 4'h0;
      {src_r, a_r, b_r, cnt_r, disp_r, tmp_r, mdata_r} <= {7{32'h00000000}};
      list_r <= 8'h00;
      idx_r <= 4'h0;
      bitpos_r <= 3'h0;
      len_r <= 6'h00;
      for (i = 0; i < `REG_CNT; i = i + 1) begin
        gpr[i] <= 32'h00000000;
      end
      {mem_req_r, mem_we_r} <= 2'h0;
      mem_size_r <= `SZ_B;
      {mem_addr_r, mem_wdata_r} <= {2{32'h00000000}};
      {busy_r, done_r, result_valid_r, branch_r} <= 4'h0;
      {trap_r, regs_valid_r, pc_valid_r, int_end_r} <= 4'h0;
      {result_r, sp_r, fp_r, pc_r} <= {4{32'h00000000}};
      psr_r <= 16'h0000;
      flags_r <= 5'h00;
    end else begin
      done_r <= 1'b0;
      result_valid_r <= 1'b0;
      branch_r <= 1'b0;
      trap_r <= 1'b0;
      regs_valid_r <= 1'b0;
      pc_valid_r <= 1'b0;
      int_end_r <= 1'b0;
      case (state_r)
        `ST_IDLE: begin
          if (START) begin
            op_r <= OP;
            size_r <= SIZE;
            {back_r, until_r, while_r, xlat_r} <= {OPT_BACK, OPT_UNTIL, OPT_WHILE, OPT_XLAT};
            src_r <= SRC;
            a_r <= SRC;
            b_r <= DST;
            cnt_r <= DISP;
            disp_r <= DISP;
            list_r <= REG_LIST;
            idx_r <= 4'h0;
            phase_r <= 3'h0;
            sp_r <= SP_IN;
            fp_r <= FP_IN;
            flags_r <= FLAGS_IN;
            bitpos_r <= foff[2:0];
            len_r <= flen;
            for (i = 0; i < `REG_CNT; i = i + 1) begin
              gpr[i] <= REGS_IN[i*32 +: 32];
            end
            case (OP)
              `OP_QCMP: begin
                flags_r <= alu_flags;
                done_r <= 1'b1;
              end
              `OP_BINV, `OP_SCOND, `OP_LSH, `OP_ASH, `OP_ROT, `OP_INDEX: begin
                result_r <= alu_res;
                result_valid_r <= 1'b1;
                done_r <= 1'b1;
              end
              `OP_ACB: begin
                result_r <= alu_res;
                result_valid_r <= 1'b1;
                branch_r <= (alu_res != 32'h00000000);
                done_r <= 1'b1;
              end
              `OP_BCMP: begin
                if (DISP < `BCMP_MIN || DISP > `BCMP_MAX) begin
                  trap_r <= 1'b1;
                  done_r <= 1'b1;
                end else begin
                  busy_r <= 1'b1;
                  state_r <= `ST_STEP;
                end
              end
              `OP_EXT, `OP_INS, `OP_SEXT, `OP_SINS: begin
                busy_r <= 1'b1;
                mem_go(1'b0, `SZ_D, faddr, 32'h00000000, 3'h0);
              end
              `OP_MOVS, `OP_CMPS, `OP_SKPS, `OP_ENTER, `OP_EXIT: begin
                busy_r <= 1'b1;
                state_r <= `ST_STEP;
                flags_r <= cmp_flags(32'h00000000, 32'h00000000, FLAGS_IN);
              end
              `OP_TRET, `OP_IRET: begin
                if (!SUPERVISOR) begin
                  trap_r <= 1'b1;
                  done_r <= 1'b1;
                end else begin
                  busy_r <= 1'b1;
                  state_r <= `ST_STEP;
                end
              end
              default: begin
                trap_r <= 1'b1;
                done_r <= 1'b1;
              end
            endcase
          end
        end
        `ST_MEM: begin
          // Request holds until the memory answers; no timeout
          if (MEM_ACK) begin
            mem_req_r <= 1'b0;
            mdata_r <= MEM_RDATA & szmask(mem_size_r);
            phase_r <= ret_r;
            state_r <= `ST_STEP;
          end
        end
        `ST_STEP: begin
          case (op_r)
            `OP_BCMP: begin
              if (phase_r == 3'h0) begin
                mem_go(1'b0, `SZ_B, a_r, 32'h00000000, 3'h1);
              end else if (phase_r == 3'h1) begin
                tmp_r <= mdata_r;
                mem_go(1'b0, `SZ_B, b_r, 32'h00000000, 3'h2);
              end else begin
                flags_r <= cmp_flags(tmp_r, mdata_r, flags_r);
                if (tmp_r != mdata_r || cnt_r == `BCMP_MIN) begin
                  finish;
                end else begin
                  a_r <= a_r + `BCMP_MIN;
                  b_r <= b_r + `BCMP_MIN;
                  cnt_r <= cnt_r - `BCMP_MIN;
                  phase_r <= 3'h0;
                end
              end
            end
            `OP_EXT, `OP_SEXT: begin
              result_r <= alu_res;
              result_valid_r <= 1'b1;
              finish;
            end
            `OP_INS, `OP_SINS: begin
              if (phase_r == 3'h0) begin
                mem_go(1'b1, `SZ_D, mem_addr_r, alu_res, 3'h1);
              end else begin
                finish;
              end
            end
            `OP_MOVS, `OP_CMPS, `OP_SKPS: begin
              case (phase_r)
                3'h0: begin
                  if (gpr[`R_LIMIT] == 32'h00000000) begin
                    regs_valid_r <= 1'b1;
                    finish;
                  end else begin
                    mem_go(1'b0, size_r, gpr[`R_STR1], 32'h00000000, 3'h1);
                  end
                end
                3'h1: begin
                  tmp_r <= mdata_r;
                  if (xlat_r) begin
                    mem_go(1'b0, `SZ_B, gpr[`R_TABLE] + {24'h000000, mdata_r[7:0]},
                           32'h00000000, 3'h2);
                  end else begin
                    phase_r <= 3'h2;
                  end
                end
                3'h2: begin
                  tmp_r <= elem;
                  if ((until_r && elem == match) || (while_r && elem != match)) begin
                    flags_r[`FLG_F] <= 1'b1;
                    regs_valid_r <= 1'b1;
                    finish;
                  end else if (op_r == `OP_MOVS) begin
                    mem_go(1'b1, size_r, gpr[`R_STR2], elem, 3'h4);
                  end else if (op_r == `OP_CMPS) begin
                    mem_go(1'b0, size_r, gpr[`R_STR2], 32'h00000000, 3'h3);
                  end else begin
                    phase_r <= 3'h4;
                  end
                end
                3'h3: begin
                  flags_r <= cmp_flags(tmp_r, mdata_r, flags_r);
                  if (tmp_r != mdata_r) begin
                    regs_valid_r <= 1'b1;
                    finish;
                  end else begin
                    phase_r <= 3'h4;
                  end
                end
                default: begin
                  gpr[`R_STR1] <= gpr[`R_STR1] + step;
                  if (op_r != `OP_SKPS) begin
                    gpr[`R_STR2] <= gpr[`R_STR2] + step;
                  end
                  gpr[`R_LIMIT] <= gpr[`R_LIMIT] - 32'h00000001;
                  phase_r <= 3'h0;
                end
              endcase
            end
            `OP_ENTER: begin
              if (phase_r == 3'h0) begin
                if (idx_r[`IDX_END_BIT]) begin
                  sp_r <= sp_r - `STACK_STEP;
                  mem_go(1'b1, `SZ_D, sp_r - `STACK_STEP, fp_r, 3'h1);
                end else begin
                  if (list_r[idx_r[2:0]]) begin
                    sp_r <= sp_r - `STACK_STEP;
                    mem_go(1'b1, `SZ_D, sp_r - `STACK_STEP, gpr[idx_r[2:0]], 3'h0);
                  end
                  idx_r <= idx_r + 4'h1;
                end
              end else begin
                fp_r <= sp_r;
                sp_r <= sp_r - disp_r;
                finish;
              end
            end
            `OP_EXIT: begin
              case (phase_r)
                3'h0: begin
                  sp_r <= fp_r;
                  phase_r <= 3'h1;
                end
                3'h1: begin
                  sp_r <= sp_r + `STACK_STEP;
                  mem_go(1'b0, `SZ_D, sp_r, 32'h00000000, 3'h2);
                end
                3'h2: begin
                  fp_r <= mdata_r;
                  idx_r <= 4'h7;
                  phase_r <= 3'h3;
                end
                3'h3: begin
                  if (idx_r[`IDX_END_BIT]) begin
                    regs_valid_r <= 1'b1;
                    finish;
                  end else if (list_r[idx_r[2:0]]) begin
                    sp_r <= sp_r + `STACK_STEP;
                    mem_go(1'b0, `SZ_D, sp_r, 32'h00000000, 3'h4);
                  end else begin
                    idx_r <= idx_r - 4'h1;
                  end
                end
                default: begin
                  gpr[idx_r[2:0]] <= mdata_r;
                  idx_r <= idx_r - 4'h1;
                  phase_r <= 3'h3;
                end
              endcase
            end
            `OP_TRET, `OP_IRET: begin
              case (phase_r)
                3'h0: begin
                  sp_r <= sp_r + `STACK_STEP;
                  mem_go(1'b0, `SZ_D, sp_r, 32'h00000000, 3'h1);
                end
                3'h1: begin
                  pc_r <= mdata_r;
                  sp_r <= sp_r + `STACK_STEP;
                  mem_go(1'b0, `SZ_D, sp_r, 32'h00000000, 3'h2);
                end
                default: begin
                  psr_r <= mdata_r[15:0];
                  if (op_r == `OP_TRET) begin
                    sp_r <= sp_r + disp_r;
                  end
                  int_end_r <= (op_r == `OP_IRET);
                  pc_valid_r <= 1'b1;
                  finish;
                end
              endcase
            end
            default: finish;
          endcase
        end
        default: state_r <= `ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign MEM_REQ = mem_req_r;
  assign MEM_WE = mem_we_r;
  assign MEM_SIZE = mem_size_r;
  assign MEM_ADDR = mem_addr_r;
  assign MEM_WDATA = mem_wdata_r;
  assign BUSY = busy_r;
  assign DONE = done_r;
  assign RESULT = result_r;
  assign RESULT_VALID = result_valid_r;
  assign FLAGS_OUT = flags_r;
  assign BRANCH = branch_r;
  assign TRAP_ILLEGAL = trap_r;
  assign REGS_OUT = {gpr[7], gpr[6], gpr[5], gpr[4], gpr[3], gpr[2], gpr[1], gpr[0]};
  assign REGS_VALID = regs_valid_r;
  assign SP_OUT = sp_r;
  assign FP_OUT = fp_r;
  assign PC_OUT = pc_r;
  assign PSR_OUT = psr_r;
  assign PC_VALID = pc_valid_r;
  assign INT_END = int_end_r;
endmodule
`default_nettype wire

/* File: rtl/exec_defines.vh */
`ifndef EXEC_DEFINES_VH
`define EXEC_DEFINES_VH
// ----------------------------------------
// Operation codes
// ----------------------------------------
`define OP_QCMP 5'h00
`define OP_BCMP 5'h01
`define OP_BINV 5'h02
`define OP_SCOND 5'h03
`define OP_LSH 5'h04
`define OP_ASH 5'h05
`define OP_ROT 5'h06
`define OP_EXT 5'h07
`define OP_INS 5'h08
`define OP_SEXT 5'h09
`define OP_SINS 5'h0A
`define OP_INDEX 5'h0B
`define OP_MOVS 5'h0C
`define OP_CMPS 5'h0D
`define OP_SKPS 5'h0E
`define OP_ACB 5'h0F
`define OP_TRET 5'h10
`define OP_IRET 5'h11
`define OP_ENTER 5'h12
`define OP_EXIT 5'h13
// ----------------------------------------
// Operand lengths
// ----------------------------------------
`define SZ_B 2'h0
`define SZ_W 2'h1
`define SZ_D 2'h2
// ----------------------------------------
// Condition codes
// ----------------------------------------
`define CC_EQ 4'h0
`define CC_NE 4'h1
`define CC_CS 4'h2
`define CC_CC 4'h3
`define CC_HI 4'h4
`define CC_LS 4'h5
`define CC_GT 4'h6
`define CC_LE 4'h7
`define CC_FS 4'h8
`define CC_FC 4'h9
`define CC_LO 4'hA
`define CC_HS 4'hB
`define CC_LT 4'hC
`define CC_GE 4'hD
`define CC_TRUE 4'hE
// ----------------------------------------
// Flag bit positions
// ----------------------------------------
`define FLG_C 0
`define FLG_Z 1
`define FLG_F 2
`define FLG_L 3
`define FLG_N 4
// ----------------------------------------
// Sequencer
// ----------------------------------------
`define ST_IDLE 2'h0
`define ST_MEM 2'h1
`define ST_STEP 2'h2
`define BCMP_MIN 32'h00000001
`define BCMP_MAX 32'h00000010
`define STACK_STEP 32'h00000004
`define REG_CNT 8
`define IDX_END_BIT 3
`define R_LIMIT 0
`define R_STR1 1
`define R_STR2 2
`define R_TABLE 3
`define R_MATCH 4
`endif

/* File: rtl/int_alu.v */
`include "exec_defines.vh"
`default_nettype none
module int_alu (
  // Operation
  input wire [4:0] op,
  input wire [1:0] size,
  input wire [3:0] short_val,
  input wire [3:0] cond,
  input wire [4:0] flags_in,
  // Operands
  input wire [31:0] a,
  input wire [31:0] b,
  input wire [31:0] c,
  input wire [2:0] fpos,
  input wire [5:0] flen,
  // Results
  output reg [31:0] res,
  output reg [4:0] flags_res
);
  function [31:0] szmask;
    input [1:0] s;
    begin
      szmask = (s == `SZ_B) ? 32'h000000FF : (s == `SZ_W) ? 32'h0000FFFF : 32'hFFFFFFFF;
    end
  endfunction
  function [31:0] sext;
    input [31:0] x;
    input [1:0] s;
    begin
      sext = (s == `SZ_B) ? {{24{x[7]}}, x[7:0]} :
             (s == `SZ_W) ? {{16{x[15]}}, x[15:0]} : x;
    end
  endfunction
  wire [31:0] m = szmask(size);
  wire [31:0] bx = sext(b, size);
  wire [31:0] imm_x = {{28{short_val[3]}}, short_val};
  wire [7:0] mag = a[7] ? (8'h00 - a[7:0]) : a[7:0];
  wire [5:0] width = (size == `SZ_B) ? 6'h08 : (size == `SZ_W) ? 6'h10 : 6'h20;
  wire [5:0] rot_k = {1'b0, a[4:0]} & (width - 6'h01);
  wire [31:0] xm = b & m;
  wire [31:0] fmask = (flen[5]) ? 32'hFFFFFFFF : ((32'h00000001 << flen[4:0]) - 32'h00000001);
  wire z = flags_in[`FLG_Z];
  wire n = flags_in[`FLG_N];
  wire l = flags_in[`FLG_L];
  wire cy = flags_in[`FLG_C];
  wire fl = flags_in[`FLG_F];
  reg cond_true;
  always @* begin
    case (cond)
      `CC_EQ: cond_true = z;
      `CC_NE: cond_true = !z;
      `CC_CS: cond_true = cy;
      `CC_CC: cond_true = !cy;
      `CC_HI: cond_true = l;
      `CC_LS: cond_true = !l;
      `CC_GT: cond_true = n;
      `CC_LE: cond_true = !n;
      `CC_FS: cond_true = fl;
      `CC_FC: cond_true = !fl;
      `CC_LO: cond_true = !l && !z;
      `CC_HS: cond_true = l || z;
      `CC_LT: cond_true = !n && !z;
      `CC_GE: cond_true = n || z;
      `CC_TRUE: cond_true = 1'b1;
      default: cond_true = 1'b0;
    endcase
  end
  always @* begin
    res = 32'h00000000;
    flags_res = flags_in;
    case (op)
      `OP_QCMP: begin
        flags_res[`FLG_Z] = ((imm_x & m) == xm);
        flags_res[`FLG_N] = ($signed(sext(imm_x, size)) > $signed(bx));
        flags_res[`FLG_L] = ((imm_x & m) > xm);
      end
      `OP_BINV: res = b ^ 32'h00000001;
      `OP_SCOND: res = {31'h00000000, cond_true};
      // Counts past the width empty the value, except arithmetic right shifts, which fill it with the sign
      `OP_LSH: res = a[7] ? (xm >> mag) : (b << mag);
      `OP_ASH: res = a[7] ? $unsigned($signed(bx) >>> mag) : (b << mag);
      `OP_ROT: res = (xm << rot_k) | (xm >> (width - rot_k));
      `OP_EXT, `OP_SEXT: res = (a >> fpos) & fmask;
      `OP_INS, `OP_SINS: res = (a & ~(fmask << fpos)) | ((b & fmask) << fpos);
      `OP_INDEX: res = a * (b + 32'h00000001) + c;
      `OP_ACB: res = b + imm_x;
      default: res = 32'h00000000;
    endcase
    if (op != `OP_INS && op != `OP_SINS) begin
      res = res & m;
    end
  end
endmodule
`default_nettype wire

/* File: tb/exec_unit_properties.sv */
`include "exec_defines.vh"
`default_nettype none
module exec_unit_properties (
  // Watched ports
  input wire logic CLK, RST_N, START, BUSY, SUPERVISOR, DONE, BRANCH, TRAP_ILLEGAL, MEM_REQ,
  input wire logic [4:0] OP, FLAGS_OUT,
  input wire logic [1:0] SIZE,
  input wire logic [3:0] SHORT_VAL, COND,
  input wire logic [31:0] SRC, DST, DISP, RESULT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ---
  // Steps
  // ---
  sequence s_take(logic [4:0] code);
    START && !BUSY && OP == code && SIZE == `SZ_D;
  endsequence
  // No bus request may be raised in the cycle after a refused command
  sequence s_trap;
    TRAP_ILLEGAL && DONE ##1 !MEM_REQ;
  endsequence
  property p_qcmp;
    s_take(`OP_QCMP) |=>
      FLAGS_OUT[`FLG_Z] == ($signed($past(DST)) == $signed($past(SHORT_VAL)));
  endproperty
  a_qcmp: assert property (p_qcmp) else $error("quick compare flag wrong");
  property p_bcmp;
    s_take(`OP_BCMP) ##0 (DISP == 0 || DISP > 16) |=> s_trap;
  endproperty
  a_bcmp: assert property (p_bcmp) else $error("bad block count not refused");
  property p_binv;
    s_take(`OP_BINV) |=> DONE && RESULT == ($past(DST) ^ 32'h00000001);
  endproperty
  a_binv: assert property (p_binv) else $error("invert result wrong");
  property p_scond;
    s_take(`OP_SCOND) |=> RESULT[31:1] == 0 && (RESULT[0] || $past(COND) != `CC_TRUE);
  endproperty
  a_scond: assert property (p_scond) else $error("saved condition wrong");
  property p_lsh;
    s_take(`OP_LSH) ##0 (SRC == 1 || SRC == 32'h000000FF) |=>
      RESULT == ($past(SRC) == 1 ? $past(DST) << 1 : $past(DST) >> 1);
  endproperty
  a_lsh: assert property (p_lsh) else $error("shift direction wrong");
  property p_acb;
    s_take(`OP_ACB) |=> $signed(RESULT) == $signed($past(DST)) + $signed($past(SHORT_VAL))
      && BRANCH == (RESULT != 0);
  endproperty
  a_acb: assert property (p_acb) else $error("add and branch wrong");
  property p_tret;
    s_take(`OP_TRET) ##0 !SUPERVISOR |=> s_trap;
  endproperty
  a_tret: assert property (p_tret) else $error("user trap return ran");
  property p_iret;
    s_take(`OP_IRET) ##0 !SUPERVISOR |=> s_trap;
  endproperty
  a_iret: assert property (p_iret) else $error("user interrupt return ran");
endmodule
`default_nettype wire

/* File: tb/mem_model.sv */
`default_nettype none
module mem_model (
  // Bus
  input wire logic CLK, MEM_REQ, MEM_WE,
  input wire logic [1:0] MEM_SIZE,
  input wire logic [31:0] MEM_ADDR, MEM_WDATA,
  input wire logic [3:0] lat,
  output logic [31:0] MEM_RDATA,
  output logic MEM_ACK
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] m [0:1023];
  int n;
  initial begin
    MEM_ACK = 0;
    MEM_RDATA = 0;
    n = 0;
    foreach (m[i]) m[i] = 0;
  end
  // Read data toggles outside answers so stale values never look valid
  always @(posedge CLK) begin
    MEM_ACK <= 1'b0;
    MEM_RDATA <= ~MEM_RDATA;
    if (MEM_REQ && !MEM_ACK) begin
      if (n < lat) n <= n + 1;
      else begin
        n <= 0;
        MEM_ACK <= 1'b1;
        for (int i = 0; i < 4; i++) begin
          if (MEM_WE && i < (1 << MEM_SIZE)) m[10'(MEM_ADDR + i)] <= MEM_WDATA[8 * i +: 8];
          MEM_RDATA[8 * i +: 8] <= m[10'(MEM_ADDR + i)];
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`include "exec_defines.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, RST_N, START, OPT_BACK, OPT_UNTIL, OPT_WHILE, OPT_XLAT, SUPERVISOR, MEM_WE, MEM_ACK;
  logic BUSY, DONE, RESULT_VALID, BRANCH, TRAP_ILLEGAL, REGS_VALID, PC_VALID, INT_END, MEM_REQ;
  logic [4:0] OP, FLAGS_IN, FLAGS_OUT;
  logic [1:0] SIZE, MEM_SIZE;
  logic [3:0] SHORT_VAL, COND, lat;
  logic [7:0] IMM_OFF, IMM_LEN, REG_LIST;
  logic [15:0] PSR_OUT;
  logic [31:0] SRC, DST, AUX, DISP, SP_IN, FP_IN, MEM_ADDR, MEM_WDATA, MEM_RDATA, RESULT;
  logic [31:0] SP_OUT, FP_OUT, PC_OUT;
  logic [255:0] REGS_IN, REGS_OUT;
  int err_total = 0;
  int total_checks = 0;
  typedef struct {logic [4:0] op; logic [31:0] s, d, a, e;} row_t;
  row_t rows [8] = '{
    '{`OP_BINV, 32'h0, 32'h000000F5, 32'h0, 32'h000000F4},
    '{`OP_SCOND, 32'h0, 32'h0, 32'h0, 32'h00000001},
    '{`OP_LSH, 32'h00000001, 32'h00000008, 32'h0, 32'h00000010},
    '{`OP_LSH, 32'h000000FE, 32'h00000010, 32'h0, 32'h00000004},
    '{`OP_ASH, 32'h000000FF, 32'h80000000, 32'h0, 32'hC0000000},
    '{`OP_ROT, 32'h000000FF, 32'h00000001, 32'h0, 32'h80000000},
    '{`OP_ACB, 32'h0, 32'h00000005, 32'h0, 32'h00000004},
    '{`OP_INDEX, 32'h00000002, 32'h00000003, 32'h00000001, 32'h00000009}};
  exec_unit i_dut (.*);
  mem_model i_mem (.*);
  initial begin
    CLK = 0;
    forever #10 CLK = ~CLK;
  end
  task automatic run(input logic [4:0] op, input logic [31:0] s, d, a, x);
    int k;
    @(posedge CLK) #1 {OP, SRC, DST, AUX, DISP, START} = {op, s, d, a, x, 1'b1};
    @(posedge CLK) #1 START = 1'b0;
    for (k = 0; k < 200 && DONE !== 1'b1; k++) @(posedge CLK) #1;
    if (k == 200) err_total++;
  endtask
  task automatic chk(input logic [63:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task results;
    if (err_total == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Whole run is well under a thousand cycles
  initial begin
    #100000;
    err_total++;
    results;
  end
  initial begin
    {START, OP, SIZE, OPT_BACK, OPT_UNTIL, OPT_WHILE, OPT_XLAT, SRC, DST, AUX, DISP} = '0;
    {IMM_OFF, IMM_LEN, REG_LIST, REGS_IN, SP_IN, FP_IN, FLAGS_IN, lat} = '0;
    {SIZE, COND, SHORT_VAL, SUPERVISOR, RST_N} = {`SZ_D, `CC_TRUE, 4'hF, 1'b1, 1'b0};
    repeat (4) @(posedge CLK);
    #1 RST_N = 1'b1;
    chk({BUSY, DONE, RESULT}, 34'h0);
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].s, rows[i].d, rows[i].a, 32'h0);
      chk({RESULT_VALID, RESULT}, {1'b1, rows[i].e});
    end
    run(`OP_QCMP, 32'h0, 32'hFFFFFFFF, 32'h0, 32'h0);
    chk(FLAGS_OUT[`FLG_Z], 32'h1);
    {i_mem.m[10'h40], i_mem.m[10'h41]} = 16'hB00A;
    run(`OP_EXT, 32'h0, 32'h40, 32'h4, 32'h8);
    chk(RESULT, 32'h000000AB);
    lat = 4'h3;
    run(`OP_INS, 32'h5, 32'h40, 32'h4, 32'h4);
    chk({i_mem.m[10'h41], i_mem.m[10'h40]}, 16'h0A50);
    {IMM_OFF, IMM_LEN} = 16'h0408;
    run(`OP_SEXT, 32'h0, 32'h40, 32'h0, 32'h0);
    chk(RESULT, 32'h000000A5);
    {i_mem.m[10'h80], i_mem.m[10'h81], i_mem.m[10'h101], i_mem.m[10'h102]} = 32'h01021122;
    {SIZE, OPT_XLAT} = {`SZ_B, 1'b1};
    REGS_IN = {96'h0, 32'h2, 32'h100, 32'h90, 32'h80, 32'h2};
    run(`OP_MOVS, 32'h0, 32'h0, 32'h0, 32'h0);
    chk({i_mem.m[10'h91], i_mem.m[10'h90]}, 16'h2211);
    chk(REGS_OUT[63:0], {32'h82, 32'h0});
    {OPT_XLAT, OPT_UNTIL, OPT_BACK, lat} = {1'b0, 1'b1, 1'b1, 4'h0};
    REGS_IN = {96'h0, 32'h1, 32'h100, 32'h90, 32'h81, 32'h2};
    run(`OP_SKPS, 32'h0, 32'h0, 32'h0, 32'h0);
    chk(REGS_OUT[63:0], {32'h80, 32'h1});
    chk(FLAGS_OUT[`FLG_F], 32'h1);
    {SIZE, FLAGS_IN, COND, SUPERVISOR} = {`SZ_D, 5'h1F, `CC_EQ, 1'b0};
    run(`OP_SCOND, 32'h0, 32'h0, 32'h0, 32'h0);
    chk(RESULT, 32'h1);
    foreach (rows[i]) if (i < 3) begin
      run(i == 0 ? `OP_TRET : i == 1 ? `OP_IRET : `OP_BCMP, 32'h0, 32'h0, 32'h0, 32'h11);
      chk(TRAP_ILLEGAL, 32'h1);
    end
    run(`OP_BCMP, 32'h90, 32'h80, 32'h0, 32'h2);
    chk(FLAGS_OUT, 32'h1D);
    {SUPERVISOR, SP_IN, i_mem.m[10'h200]} = {1'b1, 32'h200, 8'h34};
    run(`OP_IRET, 32'h0, 32'h0, 32'h0, 32'h0);
    chk({PC_VALID, INT_END, PC_OUT[29:0], SP_OUT}, {2'h3, 30'h34, 32'h208});
    results;
  end
endmodule
bind exec_unit exec_unit_properties i_chk (.*);
`default_nettype wire
